// ==== rtl/bcdcc_pkg.sv ====
package bcdcc_pkg;

  // ****************************************************************
  // register map, word indices of 32-bit words
  // ****************************************************************
  localparam int         ADDR_W          = 5;
  localparam logic [2:0] IDX_CONFIG      = 3'h0;
  localparam logic [2:0] IDX_DRIFT_TRIM  = 3'h1;
  localparam logic [2:0] IDX_ALARM_CFG   = 3'h2;
  localparam logic [2:0] IDX_VALUE_LOW   = 3'h3;
  localparam logic [2:0] IDX_VALUE_HIGH  = 3'h4;
  localparam logic [2:0] IDX_ALARM_LOW   = 3'h5;
  localparam logic [2:0] IDX_ALARM_HIGH  = 3'h6;
  localparam logic [2:0] IDX_UNLOCK_KEY  = 3'h7;

  // ****************************************************************
  // field positions and key values
  // ****************************************************************
  localparam int         CFG_ENABLE_BIT  = 7;
  localparam int         CFG_UNLOCK_BIT  = 5;
  localparam int         CFG_SYNC_BIT    = 4;
  localparam int         CFG_HALF_BIT    = 3;
  localparam logic [7:0] UNLOCK_KEY_ONE  = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_TWO  = 8'hAA;

  // ****************************************************************
  // field masks and limits (bcd)
  // ****************************************************************
  localparam logic [7:0] MASK_MIN_SEC    = 8'h7F;
  localparam logic [7:0] MASK_HOUR_DAY   = 8'h3F;
  localparam logic [7:0] MASK_MONTH      = 8'h1F;
  localparam logic [7:0] MASK_WEEKDAY    = 8'h07;
  localparam logic [7:0] MASK_YEAR       = 8'hFF;
  localparam logic [7:0] BCD_ZERO        = 8'h00;
  localparam logic [7:0] BCD_ONE         = 8'h01;
  localparam logic [7:0] BCD_LAST_MINUTE_SECOND_PAIR = 8'h59;
  localparam logic [7:0] BCD_LAST_HOUR   = 8'h23;
  localparam logic [7:0] BCD_LAST_MONTH  = 8'h12;
  localparam logic [7:0] BCD_LAST_YEAR   = 8'h99;
  localparam logic [7:0] BCD_FEBRUARY    = 8'h02;
  localparam logic [7:0] BCD_DAYS_31     = 8'h31;
  localparam logic [7:0] BCD_DAYS_30     = 8'h30;
  localparam logic [7:0] BCD_DAYS_29     = 8'h29;
  localparam logic [7:0] BCD_DAYS_28     = 8'h28;
  localparam logic [2:0] WEEKDAY_LAST    = 3'h6;

  // ****************************************************************
  // timing: timekeeper ticks per second and sync window start
  // ****************************************************************
  localparam int          TK_FREQ_HZ     = 32768;
  localparam logic [16:0] PRESCALE_LAST  = 17'(TK_FREQ_HZ - 1);
  localparam logic [14:0] SYNC_START     = 15'h7FE0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0]  RST_YEAR       = 8'h00;
  localparam logic [7:0]  RST_MONTH      = 8'h01;
  localparam logic [7:0]  RST_DAY        = 8'h01;
  localparam logic [2:0]  RST_WEEKDAY    = 3'h6;
  localparam logic [7:0]  RST_FIELD      = 8'h00;
  localparam logic [16:0] RST_PRESCALE   = 17'h00000;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    KEY_IDLE  = 2'b00,
    KEY_FIRST = 2'b01,
    KEY_ARMED = 2'b10
  } bcdcc_key_t;

  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [2:0] weekday;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } bcdcc_time_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } bcdcc_avs_req_t;

  typedef struct packed {
    logic        enable;
    logic        unlock;
    logic [1:0]  value_ptr;
    logic [1:0]  alarm_ptr;
    logic [7:0]  trim;
    bcdcc_key_t  key;
    bcdcc_time_t tm;
    bcdcc_time_t alarm;
    logic [16:0] prescale;
    logic        ack;
    logic [31:0] rdata;
  } bcdcc_state_t;

endpackage : bcdcc_pkg

// ==== rtl/bcdcc_digit.sv ====
`timescale 1ns/100ps
// two-digit bcd counter step with programmable first and last value
module bcdcc_digit (
  // count inputs
  input  wire logic [7:0] i_value,
  input  wire logic       i_inc,
  input  wire logic [7:0] i_first,
  input  wire logic [7:0] i_last,
  // results
  output logic      [7:0] o_next,
  output logic            o_carry
);

  // ones digit rolls at ten so the field stays valid bcd
  always_comb begin
    o_next  = i_value;
    o_carry = 1'b0;
    if (i_inc) begin
      if (i_value == i_last) begin
        o_next  = i_first;
        o_carry = 1'b1;
      end else if (i_value[3:0] == 4'h9) begin
        o_next  = {i_value[7:4] + 4'h1, 4'h0};
      end else begin
        o_next  = {i_value[7:4], i_value[3:0] + 4'h1};
      end
    end
  end

endmodule // bcdcc_digit

// ==== rtl/bcdcc_core.sv ====
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
// Contract
// - alarm minutes/seconds hold bcd tens 0-5 in bits 6-4, ones 0-9; bit 7 zero.
// - timekeeper enable changes only while write unlock is set.
// - value window writes take effect only while write unlock is set.
// - timekeeper clock is crystal tick or internal rc tick, by the i_timekeeper_clock_select strap.
// - time of day wraps 23:59:59 to 00:00:00 and carries into the day.
// - after the last day of month 12 the date becomes 01/01, year carries.
// - year wraps from 99 to 00 with no further carry.
// - every bcd ones digit carries into its tens at ten, never sixteen.
// - day wraps to 01 after 31 or 30 depending on month.
// - february ends at 29 when year divisible by four, else 28.
// - all fields of one second or more are writable; counting resumes from them.
// - timekeeper runs while enable bit 7 is set, also during register rewrites.
// - any write to the minute/second pair clears the prescalers.
// - a write lands in its bus cycle; software avoids colliding with increments.
// - half-second bit is read-only, cleared by writing the seconds or minutes byte.
// - config bit 4 flags an imminent rollover; zero means safe access.
// - unlock bit 5 sets only on the access right after 55h then AAh key writes.
// - value pointer selects min/sec, weekday/hours, month/day, year.
// - each value-high access decrements the value pointer down to 00.
// - alarm pointer maps alarm pairs, 11 maps nothing; high access decrements.
// - once a minute four times the signed trim is added to the count.
// - date, weekday, hour writes, alarm ones too, need write unlock.
module bcdcc_core (
  // clock and reset
  input  wire logic                     i_clock,
  input  wire logic                     i_rst,
  input  wire logic                     i_clock_en,
  // timekeeper clock sources, one-cycle tick pulses
  input  wire logic                     i_xtal_tick,
  input  wire logic                     i_rc_tick,
  input  wire logic                     i_timekeeper_clock_select,
  // avalon-mm slave
  input  wire bcdcc_pkg::bcdcc_avs_req_t i_avs,
  output logic                          o_avs_waitrequest,
  output logic                   [31:0] o_avs_readdata,
  // time view
  output bcdcc_pkg::bcdcc_time_t        o_time,
  output logic                          o_half_second
);
  import bcdcc_pkg::*;

  // ****************************************************************
  // state and decode
  // ****************************************************************
  bcdcc_state_t s_r;
  bcdcc_state_t s_nxt;
  logic         req;
  logic         acc;
  logic         wr;
  logic         rd;
  logic [2:0]   idx;
  logic [7:0]   wbyte;
  logic         tk_tick;
  logic         sec_tick;
  logic         half_bit;
  logic         sync_flag;
  logic         leap;
  logic [7:0]   day_last;
  logic [7:0]   sec_n;
  logic [7:0]   min_n;
  logic [7:0]   hour_n;
  logic [7:0]   day_n;
  logic [7:0]   mon_n;
  logic [7:0]   year_n;
  logic         sec_c;
  logic         min_c;
  logic         hour_c;
  logic         day_c;
  logic         mon_c;
  logic [7:0]   val_low;
  logic [7:0]   val_high;
  logic [7:0]   alm_low;
  logic [7:0]   alm_high;
  logic [7:0]   cfg_rd;

  // a request is answered one cycle late; clock enable low holds the answer off
  assign req = i_avs.read | i_avs.write;
  assign acc = req & s_r.ack & i_clock_en;
  assign wr  = acc & i_avs.write & i_avs.byteenable[0];
  assign rd  = acc & i_avs.read;
  assign idx = i_avs.address[ADDR_W-1:2];
  assign wbyte = i_avs.writedata[7:0];

  // ****************************************************************
  // timekeeper clock and prescaler
  // ****************************************************************
  // source picked by a config strap, not by software
  assign tk_tick   = i_timekeeper_clock_select ? i_rc_tick : i_xtal_tick;
  assign sec_tick  = s_r.enable & tk_tick & (s_r.prescale == PRESCALE_LAST);
  // negative prescale values are pending trim debt and count as the first half
  assign half_bit  = ~s_r.prescale[16] & s_r.prescale[14];
  assign sync_flag = s_r.enable & ~s_r.prescale[16]
                     & (s_r.prescale[14:0] >= SYNC_START);

  // ****************************************************************
  // calendar carry chain
  // ****************************************************************
  // leap test on the bcd year: tens even with ones 0/4/8, tens odd with 2/6
  always_comb begin
    leap = s_r.tm.year[4] ? (s_r.tm.year[3:0] == 4'h2 || s_r.tm.year[3:0] == 4'h6)
                          : (s_r.tm.year[3:0] == 4'h0 || s_r.tm.year[3:0] == 4'h4 ||
                             s_r.tm.year[3:0] == 4'h8);
    unique case (s_r.tm.month)
      8'h04, 8'h06, 8'h09, 8'h11: day_last = BCD_DAYS_30;
      BCD_FEBRUARY:               day_last = leap ? BCD_DAYS_29 : BCD_DAYS_28;
      default:                    day_last = BCD_DAYS_31;
    endcase
  end

  bcdcc_digit u_sec (
    .i_value (s_r.tm.seconds),
    .i_inc   (sec_tick),
    .i_first (BCD_ZERO),
    .i_last  (BCD_LAST_MINUTE_SECOND_PAIR),
    .o_next  (sec_n),
    .o_carry (sec_c)
  );

  bcdcc_digit u_min (
    .i_value (s_r.tm.minutes),
    .i_inc   (sec_c),
    .i_first (BCD_ZERO),
    .i_last  (BCD_LAST_MINUTE_SECOND_PAIR),
    .o_next  (min_n),
    .o_carry (min_c)
  );

  // hour wrap after 23 closes the day
  bcdcc_digit u_hour (
    .i_value (s_r.tm.hours),
    .i_inc   (min_c),
    .i_first (BCD_ZERO),
    .i_last  (BCD_LAST_HOUR),
    .o_next  (hour_n),
    .o_carry (hour_c)
  );

  bcdcc_digit u_day (
    .i_value (s_r.tm.day),
    .i_inc   (hour_c),
    .i_first (BCD_ONE),
    .i_last  (day_last),
    .o_next  (day_n),
    .o_carry (day_c)
  );

  // month wrap after 12 closes the year
  bcdcc_digit u_month (
    .i_value (s_r.tm.month),
    .i_inc   (day_c),
    .i_first (BCD_ONE),
    .i_last  (BCD_LAST_MONTH),
    .o_next  (mon_n),
    .o_carry (mon_c)
  );

  // year carry is dropped
  bcdcc_digit u_year (
    .i_value (s_r.tm.year),
    .i_inc   (mon_c),
    .i_first (BCD_ZERO),
    .i_last  (BCD_LAST_YEAR),
    .o_next  (year_n),
    .o_carry ()
  );

  // ****************************************************************
  // window read views
  // ****************************************************************
  always_comb begin
    unique case (s_r.value_ptr)
      2'b00: begin
        val_high = s_r.tm.minutes;
        val_low  = s_r.tm.seconds;
      end
      2'b01: begin
        val_high = {5'h00, s_r.tm.weekday};
        val_low  = s_r.tm.hours;
      end
      2'b10: begin
        val_high = s_r.tm.month;
        val_low  = s_r.tm.day;
      end
      2'b11: begin
        val_high = BCD_ZERO;
        val_low  = s_r.tm.year;
      end
    endcase
    unique case (s_r.alarm_ptr)
      2'b00: begin
        alm_high = s_r.alarm.minutes;
        alm_low  = s_r.alarm.seconds;
      end
      2'b01: begin
        alm_high = {5'h00, s_r.alarm.weekday};
        alm_low  = s_r.alarm.hours;
      end
      2'b10: begin
        alm_high = s_r.alarm.month;
        alm_low  = s_r.alarm.day;
      end
      2'b11: begin
        alm_high = BCD_ZERO;
        alm_low  = BCD_ZERO;
      end
    endcase
    cfg_rd = 8'h00;
    cfg_rd[CFG_ENABLE_BIT] = s_r.enable;
    cfg_rd[CFG_UNLOCK_BIT] = s_r.unlock;
    cfg_rd[CFG_SYNC_BIT]   = sync_flag;
    cfg_rd[CFG_HALF_BIT]   = half_bit;
    cfg_rd[1:0]            = s_r.value_ptr;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_nxt     = s_r;
    s_nxt.ack = req & ~s_r.ack;

    // read data is captured one cycle before the accepting edge
    s_nxt.rdata = 32'h0000_0000;
    if (i_avs.read) begin
      unique case (idx)
        IDX_CONFIG:     s_nxt.rdata[7:0] = cfg_rd;
        IDX_DRIFT_TRIM: s_nxt.rdata[7:0] = s_r.trim;
        IDX_ALARM_CFG:  s_nxt.rdata[1:0] = s_r.alarm_ptr;
        IDX_VALUE_LOW:  s_nxt.rdata[7:0] = val_low;
        IDX_VALUE_HIGH: s_nxt.rdata[7:0] = val_high;
        IDX_ALARM_LOW:  s_nxt.rdata[7:0] = alm_low;
        IDX_ALARM_HIGH: s_nxt.rdata[7:0] = alm_high;
        IDX_UNLOCK_KEY: s_nxt.rdata[7:0] = 8'h00;
      endcase
    end

    // counting runs first; a software write in the same cycle overrides the field
    if (s_r.enable && tk_tick) begin
      if (sec_tick) begin
        s_nxt.prescale = RST_PRESCALE;
      end else begin
        s_nxt.prescale = s_r.prescale + 17'h00001;
      end
    end
    if (sec_c) begin
      // minute boundary: start the next second early or late by 4*trim ticks
      s_nxt.prescale = {{7{s_r.trim[7]}}, s_r.trim, 2'b00};
    end
    s_nxt.tm.seconds = sec_n;
    s_nxt.tm.minutes = min_n;
    s_nxt.tm.hours   = hour_n;
    s_nxt.tm.day     = day_n;
    s_nxt.tm.month   = mon_n;
    s_nxt.tm.year    = year_n;
    if (hour_c) begin
      s_nxt.tm.weekday = (s_r.tm.weekday == WEEKDAY_LAST) ? 3'h0
                                                          : s_r.tm.weekday + 3'h1;
    end

    // unlock key sequence; any other accepted access drops the arming
    if (acc) begin
      s_nxt.key = KEY_IDLE;
      if (wr && idx == IDX_UNLOCK_KEY) begin
        if (wbyte == UNLOCK_KEY_ONE) begin
          s_nxt.key = KEY_FIRST;
        end else if (wbyte == UNLOCK_KEY_TWO && s_r.key == KEY_FIRST) begin
          s_nxt.key = KEY_ARMED;
        end
      end
    end

    // high window accesses walk the pointers down and stop at 00
    if (acc && idx == IDX_VALUE_HIGH && s_r.value_ptr != 2'b00) begin
      s_nxt.value_ptr = s_r.value_ptr - 2'b01;
    end
    if (acc && idx == IDX_ALARM_HIGH && s_r.alarm_ptr != 2'b00) begin
      s_nxt.alarm_ptr = s_r.alarm_ptr - 2'b01;
    end

    if (wr) begin
      unique case (idx)
        IDX_CONFIG: begin
          // unlock may be dropped any time, raised only while the key is armed
          if (!wbyte[CFG_UNLOCK_BIT]) begin
            s_nxt.unlock = 1'b0;
          end else if (s_r.key == KEY_ARMED) begin
            s_nxt.unlock = 1'b1;
          end
          if (s_r.unlock) begin
            s_nxt.enable = wbyte[CFG_ENABLE_BIT];
          end
          s_nxt.value_ptr = wbyte[1:0];
        end
        IDX_DRIFT_TRIM: s_nxt.trim      = wbyte;
        IDX_ALARM_CFG:  s_nxt.alarm_ptr = wbyte[1:0];
        IDX_VALUE_LOW: begin
          if (s_r.unlock) begin
            unique case (s_r.value_ptr)
              2'b00: begin
                s_nxt.tm.seconds = wbyte & MASK_MIN_SEC;
                s_nxt.prescale   = RST_PRESCALE;
              end
              2'b01: s_nxt.tm.hours = wbyte & MASK_HOUR_DAY;
              2'b10: s_nxt.tm.day   = wbyte & MASK_HOUR_DAY;
              2'b11: s_nxt.tm.year  = wbyte & MASK_YEAR;
            endcase
          end
        end
        IDX_VALUE_HIGH: begin
          if (s_r.unlock) begin
            unique case (s_r.value_ptr)
              2'b00: begin
                s_nxt.tm.minutes = wbyte & MASK_MIN_SEC;
                s_nxt.prescale   = RST_PRESCALE;
              end
              2'b01: s_nxt.tm.weekday = wbyte[2:0];
              2'b10: s_nxt.tm.month   = wbyte & MASK_MONTH;
              2'b11: s_nxt.tm.year    = s_r.tm.year;
            endcase
          end
        end
        IDX_ALARM_LOW: begin
          unique case (s_r.alarm_ptr)
            2'b00: s_nxt.alarm.seconds = wbyte & MASK_MIN_SEC;
            2'b01: if (s_r.unlock) s_nxt.alarm.hours = wbyte & MASK_HOUR_DAY;
            2'b10: if (s_r.unlock) s_nxt.alarm.day = wbyte & MASK_HOUR_DAY;
            2'b11: s_nxt.alarm.seconds = s_r.alarm.seconds;
          endcase
        end
        IDX_ALARM_HIGH: begin
          unique case (s_r.alarm_ptr)
            2'b00: s_nxt.alarm.minutes = wbyte & MASK_MIN_SEC;
            2'b01: if (s_r.unlock) s_nxt.alarm.weekday = wbyte[2:0];
            2'b10: if (s_r.unlock) s_nxt.alarm.month = wbyte & MASK_MONTH;
            2'b11: s_nxt.alarm.minutes = s_r.alarm.minutes;
          endcase
        end
        IDX_UNLOCK_KEY: s_nxt.trim = s_r.trim;
      endcase
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // clock enable low freezes every field including the bus handshake
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s_r.enable        <= 1'b0;
      s_r.unlock        <= 1'b0;
      s_r.value_ptr     <= 2'b00;
      s_r.alarm_ptr     <= 2'b00;
      s_r.trim          <= RST_FIELD;
      s_r.key           <= KEY_IDLE;
      s_r.tm.year       <= RST_YEAR;
      s_r.tm.month      <= RST_MONTH;
      s_r.tm.day        <= RST_DAY;
      s_r.tm.weekday    <= RST_WEEKDAY;
      s_r.tm.hours      <= RST_FIELD;
      s_r.tm.minutes    <= RST_FIELD;
      s_r.tm.seconds    <= RST_FIELD;
      s_r.alarm.year    <= RST_FIELD;
      s_r.alarm.month   <= RST_MONTH;
      s_r.alarm.day     <= RST_DAY;
      s_r.alarm.weekday <= RST_WEEKDAY;
      s_r.alarm.hours   <= RST_FIELD;
      s_r.alarm.minutes <= RST_FIELD;
      s_r.alarm.seconds <= RST_FIELD;
      s_r.prescale      <= RST_PRESCALE;
      s_r.ack           <= 1'b0;
      s_r.rdata         <= 32'h0000_0000;
    end else if (i_clock_en) begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_avs_waitrequest = req & ~(s_r.ack & i_clock_en);
  assign o_avs_readdata    = s_r.rdata;
  assign o_time            = s_r.tm;
  assign o_half_second     = half_bit;

endmodule // bcdcc_core

// ==== test/bcdcc_core_chk.sv ====
`timescale 1ns/100ps
// ****************************************************************
// port-level checker for the calendar core
// ****************************************************************
module bcdcc_core_chk (
  // clock and reset
  input wire logic                     i_clock,
  input wire logic                     i_rst,
  input wire logic                     i_clock_en,
  // timekeeper ticks
  input wire logic                     i_xtal_tick,
  input wire logic                     i_rc_tick,
  input wire logic                     i_timekeeper_clock_select,
  // register bus
  input wire bcdcc_pkg::bcdcc_avs_req_t i_avs,
  input wire logic                     o_avs_waitrequest,
  input wire logic              [31:0] o_avs_readdata,
  // time view
  input wire bcdcc_pkg::bcdcc_time_t   o_time,
  input wire logic                     o_half_second
);
  import bcdcc_pkg::*;
  logic tick_sel;
  logic req;
  logic wr_acc;
  // selected tick and accepted write, so counting can be told from software loads
  assign tick_sel = i_timekeeper_clock_select ? i_rc_tick : i_xtal_tick;
  assign req      = i_avs.read | i_avs.write;
  assign wr_acc   = i_avs.write & ~o_avs_waitrequest;
  // last day of a bcd month; leap when tens parity and ones make a multiple of four
  function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
    if (m == BCD_FEBRUARY) return (!y[0] && (y[1] == y[4])) ? BCD_DAYS_29 : BCD_DAYS_28;
    if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) return BCD_DAYS_30;
    return BCD_DAYS_31;
  endfunction
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_wait_first: assert property (req && !$past(req) |-> o_avs_waitrequest)
    else $error("request answered in its first cycle");
  a_wait_one: assert property ((req && o_avs_waitrequest && i_clock_en) ##1 (req && i_clock_en)
    |-> !o_avs_waitrequest) else $error("more than one wait state");
  a_time_hold: assert property (!tick_sel && !wr_acc |=> $stable(o_time))
    else $error("time moved without a selected tick");
  a_day_wrap: assert property ($changed(o_time.hours) && $past(o_time.hours) == BCD_LAST_HOUR
    && !$past(wr_acc) |-> o_time.hours == BCD_ZERO && o_time.minutes == BCD_ZERO
    && o_time.seconds == BCD_ZERO && o_time.day != $past(o_time.day))
    else $error("bad wrap after last hour");
  a_year_wrap: assert property ($changed(o_time.year) && $past(o_time.year) == BCD_LAST_YEAR
    && !$past(wr_acc) |-> o_time.year == BCD_ZERO && o_time.month == BCD_ONE
    && o_time.day == BCD_ONE) else $error("bad year wrap");
  a_weekday_step: assert property ($changed(o_time.weekday) && !$past(wr_acc)
    |-> o_time.weekday == (($past(o_time.weekday) == WEEKDAY_LAST) ? 3'h0
    : $past(o_time.weekday) + 3'h1)) else $error("bad weekday step");
  a_month_end: assert property ($changed(o_time.month) && !$past(wr_acc)
    |-> $past(o_time.day) == last_day($past(o_time.month), $past(o_time.year)))
    else $error("month ended on wrong day");
  a_digit_range: assert property (o_time.seconds[3:0] < 4'hA && o_time.minutes[3:0] < 4'hA
    && o_time.hours[3:0] < 4'hA && o_time.day[3:0] < 4'hA) else $error("bcd digit over nine");
  c_year: cover property ($changed(o_time.year));
  c_month: cover property ($changed(o_time.month));
  c_read: cover property (i_avs.read && !o_avs_waitrequest);
endmodule // bcdcc_core_chk

// ==== test/bcd_calendar_clock_core_tb.sv ====
`timescale 1ns/100ps
// ****************************************************************
// self-checking bench, bus reads scored through a queue
// ****************************************************************
module bcd_calendar_clock_core_tb;
  import bcdcc_pkg::*;
  logic           i_clock, i_rst, i_xtal_tick, i_rc_tick, sel_r, ce_r;
  bcdcc_avs_req_t avs_r;
  logic           o_avs_waitrequest, o_half_second;
  logic    [31:0] o_avs_readdata;
  bcdcc_time_t    o_time;
  int             miscompares, checks;
  logic     [7:0] exp_q[$];
  logic     [7:0] v;
  bcdcc_core dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_clock_en(ce_r),
    .i_xtal_tick(i_xtal_tick), .i_rc_tick(i_rc_tick), .i_timekeeper_clock_select(sel_r),
    .i_avs(avs_r), .o_avs_waitrequest(o_avs_waitrequest), .o_avs_readdata(o_avs_readdata),
    .o_time(o_time), .o_half_second(o_half_second));
  // 40 mhz clock
  initial begin
    i_clock = 1'h0;
    forever #12.5 i_clock = ~i_clock;
  end
  task end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input logic [63:0] s, input logic [63:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // one avalon access; waitrequest sampled mid-cycle so the accepting edge is known
  task bus(input logic [4:0] a, input logic wr, input logic [7:0] d, input logic [7:0] e);
    @(posedge i_clock);
    avs_r <= '{a, ~wr, wr, {24'h0, d}, 4'hF};
    if (!wr) exp_q.push_back(e);
    @(negedge i_clock);
    while (o_avs_waitrequest !== 1'h0) @(negedge i_clock);
    @(posedge i_clock);
    avs_r <= '0;
    #1;
  endtask
  // read data stands in the accepting cycle; scored mid-cycle, clear of the edge race
  always @(negedge i_clock) begin
    if (avs_r.read && o_avs_waitrequest === 1'h0) begin
      chk("readdata", o_avs_readdata, exp_q.pop_front());
    end
  end
  // n selected ticks; the unused source gets random pulses that must not count
  task ticks(input int n);
    repeat (n) begin
      @(posedge i_clock);
      i_rc_tick <= sel_r ? 1'h1 : 1'($urandom);
      i_xtal_tick <= sel_r ? 1'($urandom) : 1'h1;
    end
    @(posedge i_clock);
    i_rc_tick <= 1'h0;
    i_xtal_tick <= 1'h0;
    #1;
  endtask
  task wv(input logic [7:0] lo, input logic [7:0] hi);
    bus(5'h0C, 1'h1, lo, 8'h00);
    bus(5'h10, 1'h1, hi, 8'h00);
  endtask
  // loads every field from pointer 11 down; high access steps the pointer
  task set_time(input logic [7:0] y, mo, d, wd, h, mi, s);
    bus(5'h00, 1'h1, 8'hA3, 8'h00);
    wv(y, 8'h00);
    wv(d, mo);
    wv(h, wd);
    wv(s, mi);
    bus(5'h00, 1'h0, 8'h00, 8'hA0);
  endtask
  // watchdog sized above the three seconds of ticks
  initial begin
    repeat (100000) @(posedge i_clock);
    miscompares++;
    end_sim;
  end
  initial begin
    avs_r = '0;
    i_rst = 1'h1;
    i_xtal_tick = 1'h0;
    i_rc_tick = 1'h0;
    sel_r = 1'h0;
    ce_r = 1'h1;
    miscompares = 0;
    checks = 0;
    v = 8'($urandom(32'hD6C1));
    repeat (4) @(posedge i_clock);
    i_rst <= 1'h0;
    wv(8'h30, 8'h12);
    chk("time", o_time, bcdcc_time_t'{RST_YEAR, RST_MONTH, RST_DAY, RST_WEEKDAY, RST_FIELD,
      RST_FIELD, RST_FIELD});
    bus(5'h1C, 1'h1, UNLOCK_KEY_ONE, 8'h00);
    bus(5'h1C, 1'h1, UNLOCK_KEY_TWO, 8'h00);
    bus(5'h00, 1'h0, 8'h00, 8'h00);
    bus(5'h00, 1'h1, 8'h80, 8'h00);
    bus(5'h00, 1'h0, 8'h00, 8'h00);
    $display("lock test done");
    bus(5'h1C, 1'h1, UNLOCK_KEY_ONE, 8'h00);
    bus(5'h1C, 1'h1, UNLOCK_KEY_TWO, 8'h00);
    bus(5'h00, 1'h1, 8'hA3, 8'h00);
    // enable bit is ignored here because unlock was still clear before this write
    bus(5'h00, 1'h0, 8'h00, 8'h23);
    v = {1'h1, 3'($urandom % 6), 4'($urandom % 10)};
    bus(5'h08, 1'h1, 8'h00, 8'h00);
    bus(5'h14, 1'h1, v, 8'h00);
    bus(5'h18, 1'h1, v, 8'h00);
    bus(5'h18, 1'h0, 8'h00, v & MASK_MIN_SEC);
    bus(5'h14, 1'h0, 8'h00, v & MASK_MIN_SEC);
    bus(5'h08, 1'h1, 8'h03, 8'h00);
    bus(5'h18, 1'h0, 8'h00, 8'h00);
    bus(5'h08, 1'h0, 8'h00, 8'h02);
    $display("unlock test done");
    set_time(8'h99, 8'h12, 8'h31, 8'h06, 8'h23, 8'h59, 8'h59);
    bus(5'h04, 1'h1, 8'h7F, 8'h00);
    ticks(32767);
    chk("time", o_time, bcdcc_time_t'{8'h99, 8'h12, 8'h31, 3'h6, 8'h23, 8'h59, 8'h59});
    ticks(1);
    chk("time", o_time, bcdcc_time_t'{8'h00, 8'h01, 8'h01, 3'h0, 8'h00, 8'h00, 8'h00});
    $display("rollover test done");
    @(posedge i_clock);
    sel_r <= 1'h1;
    ticks(32259);
    bus(5'h00, 1'h0, 8'h00, 8'hB8);
    chk("seconds", o_time.seconds, 8'h00);
    ticks(1);
    chk("seconds", o_time.seconds, 8'h01);
    $display("trim test done");
    ticks(100);
    set_time(8'h04, 8'h02, 8'h28, 8'h03, 8'h23, 8'h59, 8'h59);
    ticks(32767);
    chk("half", o_half_second, 1'h1);
    chk("seconds", o_time.seconds, 8'h59);
    // a tick that arrives while the clock enable is low is lost
    @(posedge i_clock);
    ce_r <= 1'h0;
    ticks(1);
    chk("seconds", o_time.seconds, 8'h59);
    @(posedge i_clock);
    ce_r <= 1'h1;
    ticks(1);
    chk("time", o_time, bcdcc_time_t'{8'h04, 8'h02, 8'h29, 3'h4, 8'h00, 8'h00, 8'h00});
    $display("leap test done");
    end_sim;
  end
endmodule // bcd_calendar_clock_core_tb
bind bcdcc_core bcdcc_core_chk chk_u (.i_clock(i_clock), .i_rst(i_rst),
  .i_clock_en(i_clock_en), .i_xtal_tick(i_xtal_tick), .i_rc_tick(i_rc_tick),
  .i_timekeeper_clock_select(i_timekeeper_clock_select), .i_avs(i_avs),
  .o_avs_waitrequest(o_avs_waitrequest), .o_avs_readdata(o_avs_readdata),
  .o_time(o_time), .o_half_second(o_half_second));
